// *** resolver_port_pkg.sv ***
// Purpose: shared constants and types of the resolver angle output port
// Assumes: one 200 MHz clock, all host pins asynchronous to it
// Notes:   field positions of the 16-bit serial word live here

// ****************************************************************
// package
// ****************************************************************
package resolver_port_pkg;

    localparam int ANGLE_W   = 12;
    localparam int SHIFT_W   = 16;
    localparam int PIN_W     = 6;

    // bus pins reused in serial mode
    localparam int BIT_SO    = 11;
    localparam int BIT_SCLK  = 10;

    // serial word layout
    localparam int SH_DATA_LSB = 4;
    localparam int SH_SEL      = 3;
    localparam int SH_DOS      = 2;
    localparam int SH_LOT      = 1;
    localparam int SH_PAR      = 0;

    // values after reset, velocity limits, integrator step and default mismatch limit
    localparam logic [11:0] POS_RST     = 12'h000;
    localparam logic [11:0] VEL_RST     = 12'h000;
    localparam logic [11:0] MON_MIN_RST = 12'hFFF;
    localparam logic [11:0] MON_MAX_RST = 12'h000;
    localparam logic [11:0] VEL_MAX     = 12'h7FF;
    localparam logic [11:0] VEL_MIN     = 12'h800;
    localparam logic [11:0] LSB_STEP    = 12'h001;
    localparam logic [11:0] MISMATCH_LIM_DEF = 12'h040;

    // pins idle high after reset
    localparam logic [5:0]  PINS_RST    = 6'h3F;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_PAR  = 2'b01,
        RD_SER  = 2'b10
    } read_state_t;

    // host-side pins, all active levels as on the package
    typedef struct packed {
        logic snap_n;
        logic cs_n;
        logic rd_n;
        logic pos_sel;
        logic ser_n;
        logic sclk;
    } pins_t;

    // fault flags from the front end, active high
    typedef struct packed {
        logic loss;
        logic degrade;
        logic track;
    } faults_t;

endpackage

// *** pin_sync.sv ***
// Purpose: two-stage synchroniser for asynchronous host pins
// Assumes: stage one is read only by stage two
// Notes:   frozen by the clock enable like every other state

module pin_sync
    import resolver_port_pkg::*;
#(
    parameter int          W       = PIN_W,
    parameter logic [W-1:0] RST_VAL = '1
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    // pins
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_r;
    logic [W-1:0] sync_nxt;

    always_comb begin
        meta_nxt = ce_i ? async_i : meta_r;
        sync_nxt = ce_i ? meta_r : sync_r;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_o = sync_r;

endmodule

// *** resolver_angle_output_port.sv ***
// Purpose: tracking integrators, snapshot registers and host output port
// Assumes: host pins are asynchronous; fault flags come from logic on clk_i
// Notes:   pin sync plus output flop costs three cycles of port latency

module resolver_angle_output_port
    import resolver_port_pkg::*;
#(
    parameter logic [11:0] MISMATCH_LIM = MISMATCH_LIM_DEF
) (
    // clock, reset, enable
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    // front end
    input  wire logic [11:0]  angle_meas_i,
    input  wire logic [11:0]  monitor_mag_i,
    input  wire faults_t      faults_i,
    // host control pins
    input  wire logic         snapshot_strobe_n_i,
    input  wire logic         device_select_n_i,
    input  wire logic         read_strobe_n_i,
    input  wire logic         position_not_velocity_select_i,
    input  wire logic         serial_port_select_n_i,
    // data bus pins
    input  wire logic [11:0]  db_i,
    output logic      [11:0]  db_o,
    output logic      [11:0]  db_oe_n_o,
    // status
    output logic              mismatch_o
);

    // ****************************************************************
    // pin synchronisation and edges
    // ****************************************************************
    pins_t pins_async;
    pins_t p;
    pins_t prev_r;
    pins_t prev_nxt;

    assign pins_async = '{snap_n:  snapshot_strobe_n_i,
                          cs_n:    device_select_n_i,
                          rd_n:    read_strobe_n_i,
                          pos_sel: position_not_velocity_select_i,
                          ser_n:   serial_port_select_n_i,
                          sclk:    db_i[BIT_SCLK]};

    pin_sync #(
        .W       (PIN_W),
        .RST_VAL (PINS_RST)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .async_i (pins_async),
        .sync_o  (p)
    );

    logic snap_fall;
    logic snap_rise;
    logic rd_fall;
    logic sclk_rise;

    always_comb begin
        prev_nxt  = ce_i ? p : prev_r;
        snap_fall = ce_i & prev_r.snap_n & ~p.snap_n;
        snap_rise = ce_i & ~prev_r.snap_n & p.snap_n;
        rd_fall   = ce_i & prev_r.rd_n & ~p.rd_n;
        sclk_rise = ce_i & ~prev_r.sclk & p.sclk;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_r <= PINS_RST;
        end else begin
            prev_r <= prev_nxt;
        end
    end

    // ****************************************************************
    // tracking integrators
    // ****************************************************************
    logic [11:0]        pos_int_r;
    logic [11:0]        pos_int_nxt;
    logic [11:0]        vel_int_r;
    logic [11:0]        vel_int_nxt;
    logic               dither_r;
    logic               dither_nxt;
    logic signed [11:0] err;
    logic               step_up;

    // never rest on zero error, so a null at 180 deg cannot hold
    // unsigned angle wraps at a full turn; no term looks at the read port
    always_comb begin
        err         = signed'(angle_meas_i - pos_int_r);
        step_up     = (err == 12'sh000) ? dither_r : ~err[11];
        dither_nxt  = dither_r;
        pos_int_nxt = pos_int_r;
        vel_int_nxt = vel_int_r;
        if (ce_i) begin
            dither_nxt  = ~dither_r;
            pos_int_nxt = step_up ? pos_int_r + LSB_STEP : pos_int_r - LSB_STEP;
            if (step_up && vel_int_r != VEL_MAX) begin
                vel_int_nxt = vel_int_r + LSB_STEP;
            end else if (!step_up && vel_int_r != VEL_MIN) begin
                vel_int_nxt = vel_int_r - LSB_STEP;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pos_int_r <= POS_RST;
            vel_int_r <= VEL_RST;
            dither_r  <= 1'b0;
        end else begin
            pos_int_r <= pos_int_nxt;
            vel_int_r <= vel_int_nxt;
            dither_r  <= dither_nxt;
        end
    end

    // ****************************************************************
    // snapshot registers and monitor extremes
    // ****************************************************************
    logic [11:0] pos_snap_r;
    logic [11:0] pos_snap_nxt;
    logic [11:0] vel_snap_r;
    logic [11:0] vel_snap_nxt;
    logic [11:0] mon_min_r;
    logic [11:0] mon_min_nxt;
    logic [11:0] mon_max_r;
    logic [11:0] mon_max_nxt;
    logic        mismatch_r;
    logic        mismatch_nxt;

    always_comb begin
        pos_snap_nxt = pos_snap_r;
        vel_snap_nxt = vel_snap_r;
        // copy on the falling edge only
        if (snap_fall) begin
            pos_snap_nxt = pos_int_r;
            vel_snap_nxt = vel_int_r;
        end
        mon_min_nxt = mon_min_r;
        mon_max_nxt = mon_max_r;
        if (snap_rise) begin
            mon_min_nxt = MON_MIN_RST;
            mon_max_nxt = MON_MAX_RST;
        end else if (ce_i) begin
            if (monitor_mag_i < mon_min_r) begin
                mon_min_nxt = monitor_mag_i;
            end
            if (monitor_mag_i > mon_max_r) begin
                mon_max_nxt = monitor_mag_i;
            end
        end
        // empty window after a clear reads as no mismatch
        mismatch_nxt = (mon_max_r >= mon_min_r) &&
                       ((mon_max_r - mon_min_r) > MISMATCH_LIM);
        if (!ce_i) begin
            mismatch_nxt = mismatch_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pos_snap_r <= POS_RST;
            vel_snap_r <= VEL_RST;
            mon_min_r  <= MON_MIN_RST;
            mon_max_r  <= MON_MAX_RST;
            mismatch_r <= 1'b0;
        end else begin
            pos_snap_r <= pos_snap_nxt;
            vel_snap_r <= vel_snap_nxt;
            mon_min_r  <= mon_min_nxt;
            mon_max_r  <= mon_max_nxt;
            mismatch_r <= mismatch_nxt;
        end
    end

    assign mismatch_o = mismatch_r;

    // ****************************************************************
    // read port
    // ****************************************************************
    read_state_t        st_r;
    read_state_t        st_nxt;
    logic [11:0]        out_buf_r;
    logic [11:0]        out_buf_nxt;
    logic [SHIFT_W-1:0] shift_r;
    logic [SHIFT_W-1:0] shift_nxt;
    logic [11:0]        db_r;
    logic [11:0]        db_nxt;
    logic [11:0]        oe_n_r;
    logic [11:0]        oe_n_nxt;
    logic [11:0]        sel_data;
    logic [SHIFT_W-1:0] word;
    logic               active;

    always_comb begin
        sel_data = p.pos_sel ? pos_snap_r : vel_snap_r;
        // fault flags only fill status bits, data passes untouched
        word                                  = '0;
        word[SHIFT_W-1:SH_DATA_LSB]           = sel_data;
        word[SH_SEL]                          = p.pos_sel;
        word[SH_DOS]                          = ~(faults_i.degrade | faults_i.loss);
        word[SH_LOT]                          = ~(faults_i.track | faults_i.loss);
        word[SH_PAR]                          = ~(^word[SHIFT_W-1:1]);
        active      = ~p.cs_n & ~p.rd_n;
        st_nxt      = st_r;
        out_buf_nxt = out_buf_r;
        shift_nxt   = shift_r;
        // transfer to the output register only with select low
        // load on the read strobe falling edge
        if (rd_fall && !p.cs_n) begin
            out_buf_nxt = sel_data;
            shift_nxt   = word;
        end else if (sclk_rise && st_r == RD_SER) begin
            shift_nxt = {shift_r[SHIFT_W-2:0], 1'b0};
        end
        if (ce_i) begin
            case (st_r)
                RD_IDLE: begin
                    if (rd_fall && !p.cs_n) begin
                        st_nxt = p.ser_n ? RD_PAR : RD_SER;
                    end
                end
                // strobe or select high ends the read
                RD_PAR:  st_nxt = active ? RD_PAR : RD_IDLE;
                RD_SER:  st_nxt = active ? RD_SER : RD_IDLE;
                default: st_nxt = RD_IDLE;
            endcase
        end
        db_nxt   = db_r;
        oe_n_nxt = oe_n_r;
        if (ce_i) begin
            db_nxt   = '0;
            oe_n_nxt = '1;
            if (active && p.ser_n) begin
                // drive as soon as the strobes are seen low
                db_nxt   = (st_r == RD_PAR) ? out_buf_r : sel_data;
                oe_n_nxt = '0;
            end else if (active) begin
                // only the serial output bit drives
                db_nxt[BIT_SO]   = (st_r == RD_SER) ? shift_r[SHIFT_W-1]
                                                    : word[SHIFT_W-1];
                oe_n_nxt[BIT_SO] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r      <= RD_IDLE;
            out_buf_r <= POS_RST;
            shift_r   <= '0;
            db_r      <= '0;
            oe_n_r    <= '1;
        end else begin
            st_r      <= st_nxt;
            out_buf_r <= out_buf_nxt;
            shift_r   <= shift_nxt;
            db_r      <= db_nxt;
            oe_n_r    <= oe_n_nxt;
        end
    end

    assign db_o      = db_r;
    assign db_oe_n_o = oe_n_r;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    lsb_step_a: assert property (ce_i |=> (pos_int_r == $past(pos_int_r) + LSB_STEP) ||
                                          (pos_int_r == $past(pos_int_r) - LSB_STEP))
        else $error("integrator did not move one LSB");
    snap_load_a: assert property (snap_fall |=> pos_snap_r == $past(pos_int_r) &&
                                              vel_snap_r == $past(vel_int_r))
        else $error("snapshot not loaded from integrators");
    snap_hold_a: assert property (!snap_fall |=> $stable(pos_snap_r) &&
                                                $stable(vel_snap_r))
        else $error("snapshot changed without strobe");
    mon_clear_a: assert property (snap_rise |=> mon_min_r == MON_MIN_RST &&
                                              mon_max_r == MON_MAX_RST)
        else $error("monitor extremes not cleared");
    out_load_a: assert property (rd_fall && !p.cs_n |=> out_buf_r ==
                                 ($past(p.pos_sel) ? $past(pos_snap_r) : $past(vel_snap_r)))
        else $error("output buffer holds wrong register");
    bus_float_a: assert property (ce_i && (p.cs_n || p.rd_n) |=> &db_oe_n_o)
        else $error("bus driven without select and strobe");
    par_drive_a: assert property (ce_i && !p.cs_n && !p.rd_n && p.ser_n
                                  |=> db_oe_n_o == 12'h000)
        else $error("parallel bus not driven");
    ser_float_a: assert property (ce_i && !p.ser_n |=> &db_oe_n_o[9:0] &&
                                                      db_oe_n_o[BIT_SCLK])
        else $error("serial mode drives a floating pin");
    fault_data_a: assert property (ce_i && st_r == RD_PAR && active && p.ser_n &&
                                   (|faults_i) |=> db_o == $past(out_buf_r))
        else $error("fault altered bus data");

    snap_c:    cover property (snap_fall ##[1:50] snap_rise);
    par_rd_c:  cover property (rd_fall && !p.cs_n && p.ser_n ##1 st_r == RD_PAR);
    ser_rd_c:  cover property (st_r == RD_SER && sclk_rise);
    fault_c:   cover property (st_r == RD_PAR && faults_i.loss);

endmodule

// *** host_model.sv ***
// Purpose: host model that strobes, selects and reads the angle port
// Assumes: every task is entered just after a rising clock edge
// Notes:   released bus lines show a toggling pattern, except the shift clock pin, held at sclk in serial mode

// ****************************************************************
// host model
// ****************************************************************
module host_model
    import resolver_port_pkg::*;
(
    // clock
    input  wire logic        clk_i,
    // device bus side
    input  wire logic [11:0] db_o_i,
    input  wire logic [11:0] db_oe_n_i,
    // host pins
    output pins_t            pins_o,
    output logic      [11:0] db_pin_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic toggle_r = 1'b0;

    initial pins_o = pins_t'(PINS_RST);

    always @(posedge clk_i) begin
        toggle_r <= ~toggle_r;
    end

    always_comb begin
        for (int b = 0; b < 12; b++) begin
            if (!db_oe_n_i[b]) begin
                db_pin_o[b] = db_o_i[b];
            end else if (b == BIT_SCLK && !pins_o.ser_n) begin
                db_pin_o[b] = pins_o.sclk;
            end else begin
                db_pin_o[b] = toggle_r ^ b[0];
            end
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic wait_oe(input logic [11:0] mask, input logic [11:0] val, output bit seen);
        int n;
        n = 0;
        while ((db_oe_n_i & mask) !== val && n < 6) begin
            tick(1);
            n++;
        end
        seen = (n < 6);
    endtask

    // latch time, then wait before reading
    task automatic snapshot();
        pins_o.snap_n = 1'b0;
        tick(4);
        pins_o.snap_n = 1'b1;
        tick(8);
    endtask

    // select set up one cycle ahead; recovery after release
    task automatic read_par(input logic sel, input logic use_cs, output logic [11:0] data,
                            output bit seen, output bit rel);
        pins_o.pos_sel = sel;
        tick(1);
        pins_o.cs_n = !use_cs;
        pins_o.rd_n = 1'b0;
        wait_oe(12'hFFF, 12'h000, seen);
        data = db_o_i;
        tick(1);
        pins_o.rd_n = 1'b1;
        pins_o.cs_n = 1'b1;
        wait_oe(12'hFFF, 12'hFFF, rel);
        tick(2);
    endtask

    // shift clock period of twelve cycles, idle high outside frames
    task automatic read_ser(input logic sel, output logic [16:0] bits, output bit seen);
        bit rel;
        pins_o.ser_n = 1'b0;
        pins_o.pos_sel = sel;
        tick(1);
        pins_o.cs_n = 1'b0;
        pins_o.rd_n = 1'b0;
        wait_oe(12'h800, 12'h000, seen);
        seen = seen && (db_oe_n_i[10:0] === 11'h7FF);
        for (int i = 16; i >= 0; i--) begin
            pins_o.sclk = 1'b0;
            tick(6);
            bits[i] = db_o_i[BIT_SO];
            pins_o.sclk = 1'b1;
            tick(6);
        end
        pins_o.rd_n = 1'b1;
        pins_o.cs_n = 1'b1;
        wait_oe(12'hFFF, 12'hFFF, rel);
        seen = seen && rel;
        pins_o.ser_n = 1'b1;
        tick(2);
    endtask
endmodule

// *** tb_top.sv ***
// Purpose: self-checking bench for the resolver angle output port
// Assumes: host pins driven by host_model one delay step after the edge
// Notes:   settled position may sit one step either side of the target

// ****************************************************************
// bench top
// ****************************************************************
module tb_top
    import resolver_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk;
    logic        rst;
    logic        ce;
    logic [11:0] angle;
    logic [11:0] monitor;
    faults_t     faults;
    pins_t       pins;
    logic [11:0] db_pin;
    logic [11:0] db_out;
    logic [11:0] db_oe_n;
    logic        mismatch;
    logic [11:0] p1, p2, pd, vd, rd_val;
    logic [16:0] bits;
    logic [3:0]  cases [5] = '{4'b1000, 4'b1100, 4'b1010, 4'b1001, 4'b0111};
    bit          seen, rel;
    int          c1;
    int          cyc = 0;
    int          num_errors = 0;
    int          total_checks = 0;

    resolver_angle_output_port uut (
        .clk_i                          (clk),
        .rst_i                          (rst),
        .ce_i                           (ce),
        .angle_meas_i                   (angle),
        .monitor_mag_i                  (monitor),
        .faults_i                       (faults),
        .snapshot_strobe_n_i            (pins.snap_n),
        .device_select_n_i              (pins.cs_n),
        .read_strobe_n_i                (pins.rd_n),
        .position_not_velocity_select_i (pins.pos_sel),
        .serial_port_select_n_i         (pins.ser_n),
        .db_i                           (db_pin),
        .db_o                           (db_out),
        .db_oe_n_o                      (db_oe_n),
        .mismatch_o                     (mismatch)
    );

    host_model host (
        .clk_i     (clk),
        .db_o_i    (db_out),
        .db_oe_n_i (db_oe_n),
        .pins_o    (pins),
        .db_pin_o  (db_pin)
    );

    // ****************************************************************
    // clock, timeout, reporting
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // the whole run needs well under 8000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            $display("[ERR] cycle limit expected finish seen timeout");
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // the loop dithers at zero error, so one step either way counts as on target
    function automatic logic [11:0] near(input logic [11:0] exp, input logic [11:0] got);
        logic [11:0] d;
        d = got - exp;
        return (d === 12'h001 || d === 12'hFFF) ? exp : got;
    endfunction

    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        angle = 12'h5A5;
        monitor = 12'h100;
        faults = '0;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        check("bus enable after reset", 12'hFFF, db_oe_n);
        check("bus data after reset", 12'h000, db_out);
        host.tick(2100);
        check("mismatch steady", 16'h0, mismatch);
        monitor = 12'h140;
        host.tick(1);
        monitor = 12'h100;
        host.tick(5);
        check("mismatch at limit", 16'h0, mismatch);
        monitor = 12'h141;
        host.tick(1);
        monitor = 12'h100;
        host.tick(5);
        check("mismatch over limit", 16'h1, mismatch);
        // a strobe while the enable is low must leave every flop alone
        ce = 1'b0;
        host.snapshot();
        check("mismatch frozen by enable", 16'h1, mismatch);
        check("bus idle while frozen", 12'hFFF, db_oe_n);
        ce = 1'b1;
        host.snapshot();
        check("mismatch cleared", 16'h0, mismatch);
        host.read_par(1'b1, 1'b1, pd, seen, rel);
        check("pos bus enable", 16'h1, seen);
        check("pos bus release", 16'h1, rel);
        check("pos settled", 12'h5A5, near(12'h5A5, pd));
        host.read_par(1'b1, 1'b0, rd_val, seen, rel);
        check("read without select", 16'h0, seen);
        host.read_par(1'b0, 1'b1, vd, seen, rel);
        host.read_par(1'b0, 1'b1, rd_val, seen, rel);
        check("velocity repeat", vd, rd_val);
        angle = 12'h9A5;
        host.tick(50);
        c1 = cyc;
        host.snapshot();
        host.read_par(1'b1, 1'b1, p1, seen, rel);
        host.read_par(1'b1, 1'b1, rd_val, seen, rel);
        check("pos repeat while tracking", p1, rd_val);
        while (cyc < c1 + 200) host.tick(1);
        host.snapshot();
        host.read_par(1'b1, 1'b1, p2, seen, rel);
        check("pos step per clock", 12'h0C8, 12'(p2 - p1));
        host.read_par(1'b0, 1'b1, rd_val, seen, rel);
        check("velocity sign rising", 16'h0, rd_val[11]);
        angle = p2 + 12'h800;
        host.tick(2300);
        host.snapshot();
        host.read_par(1'b1, 1'b1, pd, seen, rel);
        check("pos after half turn", angle, near(angle, pd));
        host.read_par(1'b0, 1'b1, vd, seen, rel);
        for (int k = 0; k < 5; k++) begin
            faults = faults_t'(cases[k][2:0]);
            host.read_ser(cases[k][3], bits, seen);
            check("serial frame pins", 16'h1, seen);
            check("serial data", cases[k][3] ? pd : vd, bits[16:5]);
            check("serial select bit", cases[k][3], bits[4]);
            check("serial degrade bit", !(faults.degrade || faults.loss), bits[3]);
            check("serial tracking bit", !(faults.track || faults.loss), bits[2]);
            check("serial parity", 16'h1, ^bits[16:1]);
            check("serial zero fill", 16'h0, bits[0]);
        end
        host.read_par(1'b1, 1'b1, rd_val, seen, rel); // value only compared, never trusted
        check("pos under faults", pd, rd_val);
        close_out();
    end
endmodule
